// file: logic/ppi_pkg.sv
/*
  constants for the parity fault injection and power management capability block.
  assumes byte-wide configuration accesses at the byte offsets below, bus clock only.
*/
// What this block does
// - bit 7 globally disables injection, resets one
// - disabled injection bits still stored and readable
// - bit 2: wrong parity on target read data
// - bit 1: report data parity error once
// - bit 0: report target address parity error once
// - capability identifier always reads 01h
// - next capability pointer always reads 00h
// - wake event support field reads zero
// - light and deep idle support read zero
// - init-required bit read-only, reset zero
// - aux power and wake clock bits zero
// - power spec revision field reads one
// - registers accessible any time by configuration
package ppi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets in configuration space
  localparam logic [7:0] OFS_INJECT   = 8'h43;
  localparam logic [7:0] OFS_CAP_IDENT_VALUE   = 8'hdc;
  localparam logic [7:0] OFS_CAP_NEXT = 8'hdd;
  localparam logic [7:0] OFS_CAP_LO   = 8'hde;
  localparam logic [7:0] OFS_CAP_HI   = 8'hdf;

  ////////////////////////////////////////////////////////////////////////////
  // injection register fields
  localparam int BIT_GLOBAL_DIS  = 7;
  localparam int BIT_TRIG_OFF    = 6;
  localparam int BIT_MST_ADDR    = 4;
  localparam int BIT_MST_WRITE   = 3;
  localparam int BIT_TGT_READ    = 2;
  localparam int BIT_DATA_REPORT = 1;
  localparam int BIT_TGT_ADDR    = 0;
  localparam logic [7:0] INJECT_RESET = 8'h80;
  localparam logic [7:0] INJECT_WMASK = 8'hdf;  // bit 5 reserved

  ////////////////////////////////////////////////////////////////////////////
  // capability values
  localparam logic [7:0]  CAP_IDENT_VALUE = 8'h01;
  localparam logic [7:0]  CAP_LIST_LINK   = 8'h00;
  localparam logic [4:0]  WAKE_STATE_MASK = 5'h00;
  localparam logic        DEEP_IDLE_B_CAP = 1'b0;
  localparam logic        LIGHT_IDLE_CAP  = 1'b0;
  localparam logic        INIT_REQUIRED   = 1'b0;
  localparam logic        AUX_POWER_CAP   = 1'b0;
  localparam logic        WAKE_NEEDS_CLK  = 1'b0;
  localparam logic [2:0]  POWER_SPEC_REV  = 3'h1;
  localparam logic [15:0] CAP_WORD = {WAKE_STATE_MASK, DEEP_IDLE_B_CAP, LIGHT_IDLE_CAP,
                                      3'h0, INIT_REQUIRED, AUX_POWER_CAP, WAKE_NEEDS_CLK,
                                      POWER_SPEC_REV};
  localparam logic [7:0]  READ_UNMAPPED = 8'h00;

endpackage : ppi_pkg

// file: logic/ppi_regs.sv
/*
  parity fault injection register, pad trigger control and power management
  capability bytes, reached by byte-wide configuration accesses.
  assumes the bus engine on the same clock gives one-cycle phase strobes and the
  correctly computed parity of the phase; parity is driven out one clock later.
*/
module ppi_regs (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // configuration access
  input  wire logic       cfg_req,
  input  wire logic       cfg_we,
  input  wire logic [7:0] cfg_addr,
  input  wire logic [7:0] cfg_wdata,
  output logic      [7:0] cfg_rdata_r,
  output logic            cfg_ack_r,
  // bus phase strobes from the bus engine
  input  wire logic       mst_addr_phase,
  input  wire logic       mst_wr_xfer,
  input  wire logic       tgt_rd_xfer,
  input  wire logic       mst_rd_xfer,
  input  wire logic       tgt_wr_xfer,
  input  wire logic       tgt_addr_hit,
  input  wire logic       par_calc,
  // fault outputs
  output logic            par_drive_r,
  output logic            perr_report_r,
  output logic            serr_report_r,
  // pad control
  output logic            precise_trigger_off_r
);

  ////////////////////////////////////////////////////////////////////////////
  // decode and injection terms
  logic [7:0] inject_r;
  logic       wr_inject;
  logic       inj_en;
  logic       hit_mst_addr;
  logic       hit_mst_write;
  logic       hit_tgt_read;
  logic       hit_data_rep;
  logic       hit_tgt_addr;
  logic [7:0] clear_mask;
  logic [7:0] read_nxt;

  // config write to the injection byte, possible at any time
  assign wr_inject = cfg_req & cfg_we & (cfg_addr == ppi_pkg::OFS_INJECT);
  assign inj_en    = ~inject_r[ppi_pkg::BIT_GLOBAL_DIS];

  // armed bit meets its matching phase
  assign hit_mst_addr  = inj_en & inject_r[ppi_pkg::BIT_MST_ADDR] & mst_addr_phase;
  assign hit_mst_write = inj_en & inject_r[ppi_pkg::BIT_MST_WRITE] & mst_wr_xfer;
  assign hit_tgt_read  = inj_en & inject_r[ppi_pkg::BIT_TGT_READ] & tgt_rd_xfer;
  assign hit_data_rep  = inj_en & inject_r[ppi_pkg::BIT_DATA_REPORT]
                         & (mst_rd_xfer | tgt_wr_xfer);
  assign hit_tgt_addr  = inj_en & inject_r[ppi_pkg::BIT_TGT_ADDR] & tgt_addr_hit;

  // self-clear of each fired bit
  always_comb begin
    clear_mask = 8'h00;
    clear_mask[ppi_pkg::BIT_MST_ADDR]    = hit_mst_addr;
    clear_mask[ppi_pkg::BIT_MST_WRITE]   = hit_mst_write;
    clear_mask[ppi_pkg::BIT_TGT_READ]    = hit_tgt_read;
    clear_mask[ppi_pkg::BIT_DATA_REPORT] = hit_data_rep;
    clear_mask[ppi_pkg::BIT_TGT_ADDR]    = hit_tgt_addr;
  end

  ////////////////////////////////////////////////////////////////////////////
  // injection register: a software write wins over a self-clear
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      inject_r <= ppi_pkg::INJECT_RESET;
    end else if (wr_inject) begin
      inject_r <= cfg_wdata & ppi_pkg::INJECT_WMASK;
    end else begin
      inject_r <= inject_r & ~clear_mask;
    end
  end

  // pad trigger control follows bit 6
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      precise_trigger_off_r <= 1'b0;
    end else if (wr_inject) begin
      precise_trigger_off_r <= cfg_wdata[ppi_pkg::BIT_TRIG_OFF];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // parity drive: correct parity, inverted when a master address, master write or target read fault fires
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      par_drive_r <= 1'b0;
    end else begin
      par_drive_r <= par_calc ^ (hit_mst_addr | hit_mst_write | hit_tgt_read);
    end
  end

  // data parity error report, one-cycle pulse
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      perr_report_r <= 1'b0;
    end else begin
      perr_report_r <= hit_data_rep;
    end
  end

  // address parity error report on system error, one-cycle pulse
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      serr_report_r <= 1'b0;
    end else begin
      serr_report_r <= hit_tgt_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data mux
  always_comb begin
    case (cfg_addr)
      ppi_pkg::OFS_INJECT:   read_nxt = inject_r;
      ppi_pkg::OFS_CAP_IDENT_VALUE:   read_nxt = ppi_pkg::CAP_IDENT_VALUE;
      ppi_pkg::OFS_CAP_NEXT: read_nxt = ppi_pkg::CAP_LIST_LINK;
      ppi_pkg::OFS_CAP_LO:   read_nxt = ppi_pkg::CAP_WORD[7:0];
      ppi_pkg::OFS_CAP_HI:   read_nxt = ppi_pkg::CAP_WORD[15:8];
      default:               read_nxt = ppi_pkg::READ_UNMAPPED;
    endcase
  end

  // answer every access one clock after it is taken
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ack_r   <= 1'b0;
      cfg_rdata_r <= 8'h00;
    end else begin
      cfg_ack_r <= cfg_req;
      if (cfg_req && !cfg_we) begin
        cfg_rdata_r <= read_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_disabled_no_fault;
    inject_r[ppi_pkg::BIT_GLOBAL_DIS] |=> !perr_report_r && !serr_report_r
                                          && (par_drive_r == $past(par_calc));
  endproperty
  a_disabled_no_fault: assert property (p_disabled_no_fault)
    else $error("fault produced while injection disabled");

  property p_disabled_keeps;
    inject_r[ppi_pkg::BIT_GLOBAL_DIS] && !wr_inject |=> $stable(inject_r);
  endproperty
  a_disabled_keeps: assert property (p_disabled_keeps)
    else $error("injection bits changed while disabled");

  property p_trigger_write;
    wr_inject |=> precise_trigger_off_r == $past(cfg_wdata[ppi_pkg::BIT_TRIG_OFF]);
  endproperty
  a_trigger_write: assert property (p_trigger_write)
    else $error("trigger control did not follow write");

  property p_mst_addr;
    !inject_r[ppi_pkg::BIT_GLOBAL_DIS] && inject_r[ppi_pkg::BIT_MST_ADDR]
      && mst_addr_phase && !wr_inject
      |=> (par_drive_r != $past(par_calc)) && !inject_r[ppi_pkg::BIT_MST_ADDR];
  endproperty
  a_mst_addr: assert property (p_mst_addr)
    else $error("master address fault not injected");

  property p_mst_write;
    !inject_r[ppi_pkg::BIT_GLOBAL_DIS] && inject_r[ppi_pkg::BIT_MST_WRITE]
      && mst_wr_xfer && !wr_inject
      |=> (par_drive_r != $past(par_calc)) && !inject_r[ppi_pkg::BIT_MST_WRITE];
  endproperty
  a_mst_write: assert property (p_mst_write)
    else $error("master write fault not injected");

  property p_tgt_read;
    !inject_r[ppi_pkg::BIT_GLOBAL_DIS] && inject_r[ppi_pkg::BIT_TGT_READ]
      && tgt_rd_xfer && !wr_inject
      |=> (par_drive_r != $past(par_calc)) && !inject_r[ppi_pkg::BIT_TGT_READ];
  endproperty
  a_tgt_read: assert property (p_tgt_read)
    else $error("target read fault not injected");

  property p_data_report;
    !inject_r[ppi_pkg::BIT_GLOBAL_DIS] && inject_r[ppi_pkg::BIT_DATA_REPORT]
      && (mst_rd_xfer || tgt_wr_xfer) && !wr_inject
      |=> perr_report_r ##1 !perr_report_r;
  endproperty
  a_data_report: assert property (p_data_report)
    else $error("data parity report not one pulse");

  property p_tgt_addr;
    !inject_r[ppi_pkg::BIT_GLOBAL_DIS] && inject_r[ppi_pkg::BIT_TGT_ADDR]
      && tgt_addr_hit && !wr_inject
      |=> serr_report_r && !inject_r[ppi_pkg::BIT_TGT_ADDR];
  endproperty
  a_tgt_addr: assert property (p_tgt_addr)
    else $error("target address fault not reported");

  property p_cap_ident_value;
    cfg_req && !cfg_we && cfg_addr == ppi_pkg::OFS_CAP_IDENT_VALUE |=> cfg_ack_r && cfg_rdata_r == 8'h01;
  endproperty
  a_cap_ident_value: assert property (p_cap_ident_value)
    else $error("capability identifier wrong");

  property p_cap_next;
    cfg_req && !cfg_we && cfg_addr == ppi_pkg::OFS_CAP_NEXT |=> cfg_rdata_r == 8'h00;
  endproperty
  a_cap_next: assert property (p_cap_next)
    else $error("next pointer not zero");

  property p_cap_hi;
    cfg_req && !cfg_we && cfg_addr == ppi_pkg::OFS_CAP_HI |=> cfg_rdata_r == 8'h00;
  endproperty
  a_cap_hi: assert property (p_cap_hi)
    else $error("capability high byte not zero");

  property p_cap_lo;
    cfg_req && !cfg_we && cfg_addr == ppi_pkg::OFS_CAP_LO |=> cfg_rdata_r == 8'h01;
  endproperty
  a_cap_lo: assert property (p_cap_lo)
    else $error("capability low byte not 01h");

  property p_ack;
    cfg_req |=> cfg_ack_r;
  endproperty
  a_ack: assert property (p_ack)
    else $error("access not acknowledged");

  property p_reserved;
    wr_inject |=> inject_r[5] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved injection bit set");

  property p_clean_parity;
    !(hit_mst_addr || hit_mst_write || hit_tgt_read) |=> par_drive_r == $past(par_calc);
  endproperty
  a_clean_parity: assert property (p_clean_parity)
    else $error("parity corrupted without a fault");

  property p_write_wins;
    wr_inject |=> inject_r == ($past(cfg_wdata) & ppi_pkg::INJECT_WMASK);
  endproperty
  a_write_wins: assert property (p_write_wins)
    else $error("written injection byte not stored");

  property p_trigger_hold;
    !wr_inject |=> $stable(precise_trigger_off_r);
  endproperty
  a_trigger_hold: assert property (p_trigger_hold)
    else $error("trigger control changed without a write");

  property p_no_stray_perr;
    !(inject_r[ppi_pkg::BIT_DATA_REPORT] && !inject_r[ppi_pkg::BIT_GLOBAL_DIS]) |=> !perr_report_r;
  endproperty
  a_no_stray_perr: assert property (p_no_stray_perr)
    else $error("data parity report without armed bit");

  property p_no_stray_serr;
    !(inject_r[ppi_pkg::BIT_TGT_ADDR] && !inject_r[ppi_pkg::BIT_GLOBAL_DIS]) |=> !serr_report_r;
  endproperty
  a_no_stray_serr: assert property (p_no_stray_serr)
    else $error("address parity report without armed bit");

  property p_rdata_hold;
    !(cfg_req && !cfg_we) |=> $stable(cfg_rdata_r);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");

  property p_unmapped;
    cfg_req && !cfg_we && cfg_addr != ppi_pkg::OFS_INJECT
      && !(cfg_addr inside {[ppi_pkg::OFS_CAP_IDENT_VALUE:ppi_pkg::OFS_CAP_HI]}) |=> cfg_rdata_r == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  property p_ack_only_req;
    !cfg_req |=> !cfg_ack_r;
  endproperty
  a_ack_only_req: assert property (p_ack_only_req)
    else $error("acknowledge without an access");

  property p_other_write;
    cfg_req && cfg_we && cfg_addr != ppi_pkg::OFS_INJECT && clear_mask == 8'h00 |=> $stable(inject_r);
  endproperty
  a_other_write: assert property (p_other_write)
    else $error("write elsewhere changed injection byte");

  c_mst_addr:  cover property (hit_mst_addr ##1 par_drive_r != $past(par_calc));
  c_data_rep:  cover property (hit_data_rep ##1 perr_report_r);
  c_tgt_addr:  cover property (hit_tgt_addr ##1 serr_report_r);
  c_race:      cover property (wr_inject && (clear_mask != 8'h00));
  c_disabled:  cover property (inject_r[ppi_pkg::BIT_GLOBAL_DIS] && mst_addr_phase);

endmodule // ppi_regs

// file: sim/ppi_bus_agent.sv
/*
  bus engine model: one-cycle phase strobes and the phase parity.
  assumes requests change at the falling edge of clk_sys.
*/
module ppi_bus_agent (
  // clock
  input  wire logic       clk_sys,
  // phase request
  input  wire logic       go,
  input  wire logic [2:0] kind,
  input  wire logic       par,
  // phase strobes and parity
  output logic      [5:0] stb,
  output logic            par_calc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic idle_r = 1'b0;
  // parity line wanders between phases
  always @(negedge clk_sys) idle_r <= ~idle_r;
  // one strobe for the requested phase kind
  assign stb      = go ? (6'h01 << kind) : 6'h00;
  assign par_calc = go ? par : idle_r;
endmodule // ppi_bus_agent

// file: sim/pci_parity_inject_pm_caps_tb.sv
/*
  self-checking bench: register reads, armed one-shot faults, write races.
  assumes ppi_regs with one-cycle ack and registered fault outputs.
*/
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module pci_parity_inject_pm_caps_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys = 0, rst_b = 0, cfg_req = 0, cfg_we = 0, go = 0, par = 0;
  logic [7:0] cfg_addr = 0, cfg_wdata = 0;
  logic [2:0] kind = 0;
  wire logic [7:0] cfg_rdata_r;
  wire logic       cfg_ack_r, par_drive_r, perr_report_r, serr_report_r;
  wire logic       precise_trigger_off_r, par_calc;
  wire logic [5:0] stb;
  int         miscompares = 0, total_checks = 0;
  logic [7:0] rd_q[$];
  logic [2:0] ft_q[$];
  always #4 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  ppi_bus_agent u_agent (.clk_sys, .go, .kind, .par, .stb, .par_calc);
  ppi_regs u_dut (.clk_sys, .rst_b, .cfg_req, .cfg_we, .cfg_addr, .cfg_wdata, .cfg_rdata_r,
    .cfg_ack_r, .mst_addr_phase(stb[0]), .mst_wr_xfer(stb[1]), .tgt_rd_xfer(stb[2]),
    .mst_rd_xfer(stb[3]), .tgt_wr_xfer(stb[4]), .tgt_addr_hit(stb[5]), .par_calc,
    .par_drive_r, .perr_report_r, .serr_report_r, .precise_trigger_off_r);
  ////////////////////////////////////////////////////////////////////////////
  // injection bit armed for each phase kind
  function automatic int bit_of(int k);
    return k == 0 ? 4 : k == 1 ? 3 : k == 2 ? 2 : k < 5 ? 1 : 0;
  endfunction
  // expected {parity inverted, perr, serr}
  function automatic logic [2:0] hit_of(int b);
    return {b >= 2, b == 1, b == 0};
  endfunction
  // one config access; for reads d is the expected byte
  task automatic cfg(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    cfg_req = 1; cfg_we = w; cfg_addr = a; cfg_wdata = d;
    if (!w) rd_q.push_back(d);
    @(negedge clk_sys);
    cfg_req = 0;
  endtask
  // one bus phase with random parity
  task automatic fire(input logic [2:0] k, input logic [2:0] hit);
    logic p;
    p = 1'($urandom);
    @(negedge clk_sys);
    go = 1; kind = k; par = p;
    ft_q.push_back({p ^ hit[2], hit[1:0]});
    @(negedge clk_sys);
    go = 0;
  endtask
  task stop_test;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // result watcher: registered results settle just after the edge that takes the request
  always @(posedge clk_sys) begin
    logic r, a, p;
    logic [7:0] e8;
    logic [2:0] e3;
    r = cfg_req & ~cfg_we;
    a = cfg_req;
    p = go;
    #1;
    `CHK(cfg_ack_r, a)
    if (r) begin
      e8 = rd_q.pop_front();
      `CHK(cfg_rdata_r, e8)
    end
    if (p) begin
      e3 = ft_q.pop_front();
      `CHK({par_drive_r, perr_report_r, serr_report_r}, e3)
    end
  end
  // watchdog
  initial begin
    #100us;
    miscompares++;
    stop_test;
  end
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'h9a45_6d2a));
    repeat (6) @(negedge clk_sys);
    rst_b = 1;
    cfg(0, 8'h43, 8'h80);
    cfg(0, 8'hdc, 8'h01);
    cfg(0, 8'hdd, 8'h00);
    cfg(0, 8'hde, 8'h01);
    cfg(0, 8'hdf, 8'h00);
    cfg(0, 8'he0, 8'h00);
    $display("test reset_values done");
    cfg(1, 8'h43, 8'hff);
    cfg(1, 8'hdc, 8'hff);
    cfg(1, 8'hdf, 8'hff);
    cfg(0, 8'h43, 8'hdf);
    cfg(0, 8'hdc, 8'h01);
    cfg(0, 8'hdf, 8'h00);
    `CHK(precise_trigger_off_r, 1'b1)
    for (int k = 0; k < 6; k++) fire(3'(k), 3'b000);
    cfg(0, 8'h43, 8'hdf);
    $display("test disabled done");
    for (int k = 0; k < 6; k++) begin
      cfg(1, 8'h43, 8'(8'h01 << bit_of(k)));
      for (int j = 0; j < 6; j++) if (bit_of(j) != bit_of(k)) fire(3'(j), 3'b000);
      fire(3'(k), hit_of(bit_of(k)));
      fire(3'(k), 3'b000);
      cfg(0, 8'h43, 8'h00);
    end
    `CHK(precise_trigger_off_r, 1'b0)
    $display("test one_shot done");
    cfg(1, 8'h43, 8'h01);
    fork
      fire(3'd5, 3'b001);
      cfg(1, 8'h43, 8'h01);
    join
    cfg(0, 8'h43, 8'h01);
    $display("test write_race done");
    cfg(1, 8'h43, 8'h40);
    `CHK(precise_trigger_off_r, 1'b1)
    @(negedge clk_sys);
    rst_b = 0;
    repeat (2) @(negedge clk_sys);
    `CHK(precise_trigger_off_r, 1'b0)
    rst_b = 1;
    cfg(0, 8'h43, 8'h80);
    $display("test mid_reset done");
    repeat (2) @(negedge clk_sys);
    stop_test;
  end
endmodule // pci_parity_inject_pm_caps_tb
